// [pkg/aesp_if.sv]
// Link between the encoder port and its controller, with line resolution.
`timescale 1ns/1ps
interface aesp_if;
    logic sclk;
    logic csel;
    logic host_dat_o;
    logic host_dat_oe;
    logic dev_dat_o;
    logic dev_dat_oe;
    logic generated_select_out;
    logic wire_mode_select;
    logic test_config_input;
    logic bidir_serial_line;
    // The pull-down wins when neither end drives, so the command reads as zeros.
    assign bidir_serial_line = dev_dat_oe ? dev_dat_o : (host_dat_oe ? host_dat_o : 1'b0);
    modport dev (
        input sclk, csel, bidir_serial_line, wire_mode_select, test_config_input,
        output dev_dat_o, dev_dat_oe, generated_select_out
    );
    modport host (
        input bidir_serial_line, generated_select_out,
        output sclk, csel, host_dat_o, host_dat_oe, wire_mode_select, test_config_input
    );
endinterface

// [pkg/aesp_params.svh]
// Constants of the angle encoder serial port: frame positions and timing.
`ifndef AESP_PARAMS_SVH
`define AESP_PARAMS_SVH
// Rise index (0 based) of the last command bit of a frame.
`define AESP_CMD_LAST 5'h04
// Rise index of the first and last data bit of a frame.
`define AESP_DATA_FIRST 5'h05
`define AESP_DATA_LAST 5'h14
// Rise index of the closing clock; the following clock starts a new frame.
`define AESP_FRAME_LAST 5'h15
// Command code of the angle read.
`define AESP_CMD_READ_ANGLE 5'h00
// Data word field positions of a read frame.
`define AESP_GAIN_LSB 8
`define AESP_ANGLE_LSB 0
// Unused top bits of a read data word.
`define AESP_PAD_BITS 2'h0
// Timing figures in ns.
`define AESP_MCLK_NS 8
`define AESP_TO_MIN_NS 20000
`define AESP_TO_MAX_NS 24000
`define AESP_LINK_HALF_NS 40
`endif

// [pkg/aesp_pkg.sv]
// Types of both ends of the angle encoder serial port, one for each end.
package aesp_pkg;
    // Last seen direction of rotation for the hysteresis filter.
    typedef enum logic {aesp_dir_up, aesp_dir_dn} aesp_dir_t;
    // Controller transfer sequence.
    typedef enum logic [1:0] {hs_idle, hs_lead, hs_clk, hs_gap} aesp_hst_t;
endpackage

// [rtl/aesp_dev.sv]
// Device end of the angle encoder serial port: framing, shifting and hysteresis.
// Function
// R1: Board ties wire mode low three-wire, high two-wire.
// R2: Test configuration input held at ground always.
// R3: Five command bits MSB first, then sixteen data.
// R4: All-zero command reads angle; pull-down supplies zeros.
// R5: Device never drives line during command bits.
// R6: Device drives half clock after last command rise.
// R7: Falling chip select releases the data line.
// R8: Two-wire clock timeout generates select pulse out.
// R9: Each timeout resets the serial interface state.
// R10: Without timeout, clock 23 starts next frame.
// R11: Controller may resynchronise by inserting a timeout.
// R12: Read frame: zero command, gain code, angle.
// R13: Differential connection is read only, no writes.
// R14: One step hysteresis on reversal, software disable.
// R15: Select rise clears bit counter for command.
`timescale 1ns/1ps
`include "aesp_params.svh"
module aesp_dev #(
    parameter int TO_MIN_NS = `AESP_TO_MIN_NS
) (
    input wire logic mclk,
    input wire logic reset_n,
    aesp_if.dev lnk,
    input wire logic [7:0] raw_angle,
    input wire logic [5:0] field_gain_code,
    input wire logic hyst_disable,
    output logic [4:0] wr_cmd,
    output logic [15:0] wr_data,
    output logic wr_valid,
    output logic [7:0] angle_out
);
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int TO_CYC = (TO_MIN_NS + `AESP_MCLK_NS - 1) / `AESP_MCLK_NS;
    localparam int TOW = $clog2(TO_CYC + 1);
    localparam logic [TOW-1:0] TO_LAST = TOW'(TO_CYC - 1);

    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] dat_s;
    logic [1:0] mode_s;
    logic sclk_d_q;
    logic cs_d_q;
    logic rise;
    logic fall;
    logic two_wire;
    logic [TOW-1:0] to_cnt_q;
    logic gen_sel_q;
    logic sel_on;
    logic sel_start;
    logic [4:0] bit_q;
    logic [4:0] cmd_q;
    logic [4:0] cmd_full;
    logic read_q;
    logic [15:0] sh_q;
    logic [15:0] wsh_q;
    logic oe_q;
    logic out_q;
    aesp_pkg::aesp_dir_t dir_q;
    logic [7:0] delta;

    // -------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // -------------------------------------------------------------------
    // Every pin but the test input passes two flops; only the second stage is read, and for the clock and select its last level feeds the edge detectors.
    // The history resets to the idle low level, so no false edge follows reset.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            sclk_s <= 2'h0;
            cs_s <= 2'h0;
            dat_s <= 2'h0;
            mode_s <= 2'h0;
            sclk_d_q <= 1'b0;
            cs_d_q <= 1'b0;
        end
        else
        begin
            sclk_s <= {sclk_s[0], lnk.sclk};
            cs_s <= {cs_s[0], lnk.csel};
            dat_s <= {dat_s[0], lnk.bidir_serial_line};
            mode_s <= {mode_s[0], lnk.wire_mode_select};
            sclk_d_q <= sclk_s[1];
            cs_d_q <= cs_s[1];
        end
    end

    assign rise = sclk_s[1] && !sclk_d_q;
    assign fall = !sclk_s[1] && sclk_d_q;
    // The test input is assumed grounded; it gates nothing here. [R2]
    assign two_wire = mode_s[1]; // [R1]

    // -------------------------------------------------------------------
    // Clock timeout and framing
    // -------------------------------------------------------------------
    // Idle time since the last rising clock; saturates so it fires once.
    always_ff @(posedge mclk)
    begin
        if (!reset_n || rise)
        begin
            to_cnt_q <= '0;
        end
        else if (to_cnt_q != TOW'(TO_CYC))
        begin
            to_cnt_q <= to_cnt_q + 1'b1;
        end
    end

    // One-cycle select pulse once the idle time reaches the timeout.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            gen_sel_q <= 1'b0;
        end
        else
        begin
            gen_sel_q <= two_wire && !rise && (to_cnt_q == TO_LAST); // [R8]
        end
    end

    assign lnk.generated_select_out = gen_sel_q;
    // In two-wire mode the frame is always open and a timeout restarts it.
    assign sel_on = two_wire || cs_s[1];
    assign sel_start = two_wire ? gen_sel_q : (cs_s[1] && !cs_d_q); // [R9]

    // Rising clocks seen in the current frame.
    always_ff @(posedge mclk)
    begin
        if (!reset_n || sel_start || !sel_on)
        begin
            bit_q <= 5'h00; // [R15] [R9]
        end
        else if (rise)
        begin
            if (bit_q == `AESP_FRAME_LAST)
            begin
                bit_q <= 5'h00; // [R10]
            end
            else
            begin
                bit_q <= bit_q + 5'h01;
            end
        end
    end

    // -------------------------------------------------------------------
    // Command and data shifting
    // -------------------------------------------------------------------
    assign cmd_full = {cmd_q[3:0], dat_s[1]};

    // Command bits arrive MSB first on the first five rises.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            cmd_q <= 5'h00;
            read_q <= 1'b0;
        end
        else if (sel_start || !sel_on)
        begin
            read_q <= 1'b0;
        end
        else if (rise && bit_q <= `AESP_CMD_LAST)
        begin
            cmd_q <= cmd_full; // [R3]
            if (bit_q == `AESP_CMD_LAST)
            begin
                read_q <= (cmd_full == `AESP_CMD_READ_ANGLE); // [R4]
            end
        end
    end

    // Read word is captured at the last command rise so it cannot tear.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            sh_q <= 16'h0000;
        end
        else if (rise && bit_q == `AESP_CMD_LAST)
        begin
            sh_q <= {`AESP_PAD_BITS, field_gain_code, angle_out}; // [R12]
        end
        else if (fall && oe_q)
        begin
            sh_q <= {sh_q[14:0], 1'b0};
        end
    end

    // Line turnaround: drive on falls, never during the command phase.
    always_ff @(posedge mclk)
    begin
        if (!reset_n || sel_start || !sel_on)
        begin
            oe_q <= 1'b0; // [R7] [R9]
            out_q <= 1'b0;
        end
        else if (fall && read_q && bit_q >= `AESP_DATA_FIRST && bit_q <= `AESP_DATA_LAST)
        begin
            oe_q <= 1'b1; // [R6] [R5]
            out_q <= oe_q ? sh_q[14] : sh_q[15];
        end
        else if (fall && bit_q == `AESP_FRAME_LAST)
        begin
            oe_q <= 1'b0; // [R5]
        end
    end

    assign lnk.dev_dat_oe = oe_q;
    assign lnk.dev_dat_o = out_q;

    // Data bits of a non-read command are taken on rises and handed out.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            wsh_q <= 16'h0000;
            wr_data <= 16'h0000;
            wr_cmd <= 5'h00;
            wr_valid <= 1'b0;
        end
        else
        begin
            wr_valid <= 1'b0;
            if (rise && sel_on && !read_q && bit_q >= `AESP_DATA_FIRST && bit_q <= `AESP_DATA_LAST)
            begin
                wsh_q <= {wsh_q[14:0], dat_s[1]}; // [R3]
                if (bit_q == `AESP_DATA_LAST)
                begin
                    wr_data <= {wsh_q[14:0], dat_s[1]};
                    wr_cmd <= cmd_q;
                    wr_valid <= 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Angle hysteresis
    // -------------------------------------------------------------------
    assign delta = raw_angle - angle_out;

    // A single step against the last direction is held back for as long as the raw angle stays there.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            angle_out <= 8'h00;
            dir_q <= aesp_pkg::aesp_dir_up;
        end
        else if (hyst_disable)
        begin
            angle_out <= raw_angle; // [R14]
        end
        else if (delta != 8'h00)
        begin
            if (!((delta == 8'h01 && dir_q == aesp_pkg::aesp_dir_dn) ||
                  (delta == 8'hff && dir_q == aesp_pkg::aesp_dir_up)))
            begin
                angle_out <= raw_angle; // [R14]
                dir_q <= delta[7] ? aesp_pkg::aesp_dir_dn : aesp_pkg::aesp_dir_up;
            end
        end
    end
endmodule // aesp_dev

// [rtl/aesp_fifo.sv]
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module aesp_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic push;
    logic pop;

    // Full when the pointers differ only in the wrap bit.
    assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
    assign out_valid = (wp_q != rp_q);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp_q[AW-1:0]];

    // Storage is written without reset; only the pointers need a defined value.
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule // aesp_fifo

// [rtl/aesp_host.sv]
// Controller end of the angle encoder serial port: clock, framing and read buffer.
`timescale 1ns/1ps
`include "aesp_params.svh"
module aesp_host #(
    parameter int HALF_NS = `AESP_LINK_HALF_NS,
    parameter int TO_MAX_NS = `AESP_TO_MAX_NS,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    aesp_if.host lnk,
    input wire logic two_wire_mode,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [4:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [15:0] rd_data
);
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int HALF = (HALF_NS / `AESP_MCLK_NS < 1) ? 1 : HALF_NS / `AESP_MCLK_NS;
    localparam int GAP = (TO_MAX_NS + `AESP_MCLK_NS - 1) / `AESP_MCLK_NS + 1;
    localparam int CW = $clog2(GAP + 1);

    aesp_pkg::aesp_hst_t st_q;
    logic [CW-1:0] cnt_q;
    logic tick;
    logic sclk_q;
    logic cs_q;
    logic [4:0] rc_q;
    logic [20:0] tx_q;
    logic wr_q;
    logic oe_q;
    logic [15:0] rx_q;
    logic push_q;
    logic fifo_ready;
    logic [1:0] line_s;

    // Reply line is a pin; two flops before use.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            line_s <= 2'h0;
        end
        else
        begin
            line_s <= {line_s[0], lnk.bidir_serial_line};
        end
    end

    assign tick = (cnt_q == CW'(HALF - 1));
    assign cmd_ready = (st_q == aesp_pkg::hs_idle) && fifo_ready;
    assign lnk.sclk = sclk_q;
    assign lnk.csel = cs_q;
    assign lnk.host_dat_o = tx_q[20];
    assign lnk.host_dat_oe = oe_q;
    assign lnk.wire_mode_select = two_wire_mode; // [R1]
    assign lnk.test_config_input = 1'b0; // [R2]

    // -------------------------------------------------------------------
    // Transfer sequencer
    // -------------------------------------------------------------------
    // Starts in the gap so a two-wire device sees a timeout first.
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            st_q <= aesp_pkg::hs_gap;
            cnt_q <= '0;
            sclk_q <= 1'b0;
            cs_q <= 1'b0;
            rc_q <= 5'h00;
            tx_q <= '0;
            wr_q <= 1'b0;
            oe_q <= 1'b0;
            rx_q <= 16'h0000;
            push_q <= 1'b0;
        end
        else
        begin
            push_q <= 1'b0;
            unique case (st_q)
                aesp_pkg::hs_idle:
                begin
                    cnt_q <= '0;
                    if (cmd_valid && fifo_ready)
                    begin
                        st_q <= aesp_pkg::hs_lead;
                        tx_q <= {cmd_code, cmd_wdata}; // [R3]
                        wr_q <= (cmd_code != `AESP_CMD_READ_ANGLE); // [R13]
                        oe_q <= 1'b1;
                        cs_q <= !two_wire_mode;
                        rc_q <= 5'h00;
                    end
                end
                aesp_pkg::hs_lead:
                begin
                    cnt_q <= tick ? '0 : cnt_q + 1'b1;
                    if (tick)
                    begin
                        st_q <= aesp_pkg::hs_clk;
                    end
                end
                aesp_pkg::hs_clk:
                begin
                    cnt_q <= tick ? '0 : cnt_q + 1'b1;
                    if (tick && !sclk_q)
                    begin
                        sclk_q <= 1'b1;
                        rc_q <= rc_q + 5'h01;
                    end
                    else if (tick)
                    begin
                        // Sample just before the fall; the reply settled a half period ago.
                        if (rc_q > `AESP_DATA_FIRST && rc_q <= `AESP_FRAME_LAST)
                        begin
                            rx_q <= {rx_q[14:0], line_s[1]};
                        end
                        sclk_q <= 1'b0;
                        tx_q <= {tx_q[19:0], 1'b0};
                        if (rc_q == `AESP_DATA_FIRST)
                        begin
                            oe_q <= wr_q; // [R5]
                        end
                        else if (rc_q == `AESP_FRAME_LAST)
                        begin
                            oe_q <= 1'b0;
                        end
                        if (rc_q == `AESP_FRAME_LAST + 5'h01)
                        begin
                            st_q <= aesp_pkg::hs_gap;
                            cs_q <= 1'b0;
                            push_q <= !wr_q;
                        end
                    end
                end
                aesp_pkg::hs_gap:
                begin
                    // Two-wire needs a full timeout so the device resynchronises. [R11]
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q >= (two_wire_mode ? CW'(GAP) : CW'(HALF)))
                    begin
                        st_q <= aesp_pkg::hs_idle;
                        cnt_q <= '0;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Read buffer
    // -------------------------------------------------------------------
    // No transfer starts without room, so a finished read always fits.
    aesp_fifo #(
        .W(16),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(push_q),
        .in_ready(fifo_ready),
        .in_data(rx_q),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule // aesp_host

// [tb/aesp_monitor.sv]
// Concurrent checks on the link between the encoder port and its controller.
`timescale 1ns/1ps
module aesp_monitor #(
    parameter int TO_MIN_NS = 20000
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic csel,
    input wire logic host_dat_o,
    input wire logic host_dat_oe,
    input wire logic dev_dat_o,
    input wire logic dev_dat_oe,
    input wire logic generated_select_out,
    input wire logic wire_mode_select,
    input wire logic test_config_input,
    input wire logic bidir_serial_line
);
    localparam int TO_CYC = TO_MIN_NS / 8;
    logic sclk_q, rise, read_turn;
    logic [3:0] cmd_q;
    logic [4:0] rise_cnt_q;
    logic [15:0] idle_q;
    // ----------------------------------------
    // Frame tracking
    // ----------------------------------------
    // Edges are seen at the pin, so the checks leave room for the device's synchroniser.
    assign rise = sclk && !sclk_q;
    assign read_turn = rise && rise_cnt_q == 5'h04 && {cmd_q, bidir_serial_line} == 5'h00;
    // Last link level and the command bits shifted in so far.
    always_ff @(posedge mclk)
    begin
        sclk_q <= sclk;
        if (rise)
            cmd_q <= {cmd_q[2:0], bidir_serial_line};
    end
    // Rises of the frame; either kind of select restarts the count.
    always_ff @(posedge mclk)
    begin
        if (!reset_n || generated_select_out || (!wire_mode_select && !csel))
            rise_cnt_q <= 5'h00;
        else if (rise)
            rise_cnt_q <= (rise_cnt_q == 5'h16) ? 5'h01 : rise_cnt_q + 5'h01;
    end
    // Idle cycles; held at the top so a long pause cannot wrap into a false timeout.
    always_ff @(posedge mclk)
    begin
        if (!reset_n || rise)
            idle_q <= 16'h0000;
        else if (idle_q != 16'hffff)
            idle_q <= idle_q + 16'h0001;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    chk_cmd_quiet: assert property (rise_cnt_q < 5'h05 |-> !dev_dat_oe)
        else $error("Device drove the line during the command bits.");
    chk_turn_half: assert property (read_turn |-> !dev_dat_oe [*5] ##[1:6] dev_dat_oe)
        else $error("Device turnaround was not half a link period after the last command bit.");
    chk_no_clash: assert property (!(dev_dat_oe && host_dat_oe))
        else $error("Both ends drove the data line.");
    chk_end_release: assert property (rise_cnt_q == 5'h16 || $fell(csel) |-> !dev_dat_oe)
        else $error("Device still drove the line at the end of the frame.");
    chk_bit_hold: assert property (dev_dat_oe && rise |-> ##1 $stable(dev_dat_o) [*3])
        else $error("Device data bit changed while the link clock was high.");
    chk_pad_zero: assert property ($rose(dev_dat_oe) |-> ##2 !dev_dat_o ##10 !dev_dat_o)
        else $error("Top two bits of the read word were not zero.");
    chk_timeout_early: assert property ($rose(generated_select_out) |-> idle_q >= TO_CYC - 2)
        else $error("Generated select came before the timeout.");
    chk_timeout_due: assert property (wire_mode_select && idle_q == TO_CYC - 2 |-> ##[0:8] generated_select_out)
        else $error("Generated select missing after the timeout.");
    chk_pulse_single: assert property (generated_select_out |=> !generated_select_out)
        else $error("Generated select was longer than one cycle.");
    chk_mode_sel: assert property (wire_mode_select |-> !csel)
        else $error("Chip select raised in two-wire mode.");
    chk_test_tied: assert property (!test_config_input)
        else $error("Test configuration input was not held low.");
endmodule // aesp_monitor

// [tb/angle_encoder_serial_port_tb.sv]
// Self-checking bench joining both ends of the angle encoder serial port.
`timescale 1ns/1ps
module angle_encoder_serial_port_tb;
    logic mclk, reset_n, two_wire_mode, cmd_valid, cmd_ready, rd_valid, rd_ready, hyst_disable, wr_valid;
    logic [4:0] cmd_code, wr_cmd;
    logic [5:0] field_gain_code;
    logic [7:0] raw_angle, angle_out;
    logic [15:0] cmd_wdata, rd_data, wr_data;
    logic [20:0] wr_seen;
    logic [7:0] hy_raw [6] = '{8'h40, 8'h41, 8'h40, 8'h3f, 8'h40, 8'h40};
    logic [7:0] hy_exp [6] = '{8'h40, 8'h41, 8'h41, 8'h3f, 8'h3f, 8'h40};
    logic [4:0] wr_codes [3] = '{5'h01, 5'h10, 5'h1f};
    logic [15:0] wr_vals [3] = '{16'h8001, 16'ha55a, 16'hffff};
    int err_total = 0;
    int total_checks = 0;
    int wr_count = 0;
    int sel_count = 0;
    int sel_base;
    int i;
    // ----------------------------------------
    // Both ends, their link and the checker
    // ----------------------------------------
    aesp_if aesp_if_inst ();
    aesp_host #(.TO_MAX_NS(1000)) aesp_host_inst (
        .mclk(mclk), .reset_n(reset_n), .lnk(aesp_if_inst), .two_wire_mode(two_wire_mode),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data)
    );
    aesp_dev #(.TO_MIN_NS(800)) aesp_dev_inst (
        .mclk(mclk), .reset_n(reset_n), .lnk(aesp_if_inst), .raw_angle(raw_angle),
        .field_gain_code(field_gain_code), .hyst_disable(hyst_disable), .wr_cmd(wr_cmd),
        .wr_data(wr_data), .wr_valid(wr_valid), .angle_out(angle_out)
    );
    aesp_monitor #(.TO_MIN_NS(800)) aesp_monitor_inst (
        .mclk(mclk), .reset_n(reset_n), .sclk(aesp_if_inst.sclk), .csel(aesp_if_inst.csel),
        .host_dat_o(aesp_if_inst.host_dat_o), .host_dat_oe(aesp_if_inst.host_dat_oe),
        .dev_dat_o(aesp_if_inst.dev_dat_o), .dev_dat_oe(aesp_if_inst.dev_dat_oe),
        .generated_select_out(aesp_if_inst.generated_select_out),
        .wire_mode_select(aesp_if_inst.wire_mode_select),
        .test_config_input(aesp_if_inst.test_config_input),
        .bidir_serial_line(aesp_if_inst.bidir_serial_line)
    );
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Holds reset low for twelve cycles.
    task automatic apply_reset();
        reset_n <= 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
    endtask
    // Offers one command and holds it until the edge that takes it.
    task automatic do_cmd(input logic [4:0] code, input logic [15:0] wdata);
        int n = 0;
        @(posedge mclk);
        cmd_code <= code;
        cmd_wdata <= wdata;
        cmd_valid <= 1'b1;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 5000);
        if (cmd_ready !== 1'b1) err_total++;
        @(posedge mclk);
        cmd_valid <= 1'b0;
    endtask
    // Waits for the head of the read buffer, checks it and pops it.
    task automatic pop(input logic [15:0] exp);
        int n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (rd_valid !== 1'b1 && n < 1000);
        check("read valid", {15'h0000, rd_valid}, 16'h0001);
        check("read word", rd_data, exp);
        @(posedge mclk);
        rd_ready <= 1'b1;
        @(posedge mclk);
        rd_ready <= 1'b0;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and observers
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Allows about four times the expected length of the run.
    initial
    begin
        #320000;
        err_total++;
        complete_run();
    end
    // Write pulses last one cycle, so they are caught here rather than by polling.
    always @(posedge mclk)
    begin
        if (wr_valid === 1'b1)
        begin
            wr_count <= wr_count + 1;
            wr_seen <= {wr_cmd, wr_data};
        end
        if (aesp_if_inst.generated_select_out === 1'b1)
            sel_count <= sel_count + 1;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        reset_n = 1'b0;
        two_wire_mode = 1'b0;
        cmd_valid = 1'b0;
        rd_ready = 1'b0;
        hyst_disable = 1'b0;
        raw_angle = 8'h00;
        field_gain_code = 6'h2b;
        cmd_code = 5'h00;
        cmd_wdata = 16'h0000;
        apply_reset();
        // Reversals of one step are held until hysteresis is switched off.
        for (i = 0; i < 6; i++)
        begin
            raw_angle <= hy_raw[i];
            hyst_disable <= (i == 5);
            repeat (4) @(posedge mclk);
            @(negedge mclk);
            check("filtered angle", {8'h00, angle_out}, {8'h00, hy_exp[i]});
            @(posedge mclk);
        end
        // Non-zero commands land in the write outputs and give no read word.
        for (i = 0; i < 3; i++)
        begin
            do_cmd(wr_codes[i], wr_vals[i]);
            repeat (400) @(posedge mclk);
            check("write count", 16'(wr_count), 16'(i + 1));
            check("write command", {11'h000, wr_seen[20:16]}, {11'h000, wr_codes[i]});
            check("write data", wr_seen[15:0], wr_vals[i]);
            check("no read word", {15'h0000, rd_valid}, 16'h0000);
        end
        // Fill the read buffer while the reader stalls, then drain it.
        for (i = 0; i < 32; i++)
        begin
            raw_angle <= 8'(i * 7);
            do_cmd(5'h00, 16'h0000);
            repeat (80) @(posedge mclk);
        end
        repeat (300) @(posedge mclk);
        @(negedge mclk);
        check("ready when full", {15'h0000, cmd_ready}, 16'h0000);
        for (i = 0; i < 32; i++)
            pop({2'b00, 6'h2b, 8'(i * 7)});
        @(negedge mclk);
        check("buffer empty", {15'h0000, rd_valid}, 16'h0000);
        // Two-wire reads, each framed by a generated select after the timeout.
        two_wire_mode <= 1'b1;
        apply_reset();
        sel_base = sel_count;
        raw_angle <= 8'hc3;
        do_cmd(5'h00, 16'h0000);
        pop(16'h2bc3);
        raw_angle <= 8'h3c;
        do_cmd(5'h00, 16'h0000);
        pop(16'h2b3c);
        repeat (200) @(posedge mclk);
        check("select pulses", 16'(sel_count - sel_base), 16'h0003);
        complete_run();
    end
endmodule // angle_encoder_serial_port_tb
